// *** core/im_pkg.sv ***
// Constants and types for the interrupt cause and moderation block.
// Assumes a 100 MHz core clock and an AXI4-Lite register bus.
`default_nettype none
package im_pkg;
  // Sizes
  localparam int NV = 16;  // Vectors and throttle counters
  localparam int NQ = 16;  // Queue event inputs
  localparam int NENT = NQ + 2;  // Allocation entries
  localparam int E_TIMER = NQ;
  localparam int E_OTHER = NQ + 1;
  localparam int ALLOC_WORDS = (NENT + 7) / 8;
  localparam int IW = 16;  // Throttle interval width
  localparam int AW = 8;
  localparam int NLEG = 7;
  // Cause bit positions
  localparam int B_TIMER = 16;
  localparam int B_LEG = 17;
  localparam int B_OTHER = 31;
  localparam logic [31:0] OTHER_BITS = 32'h80fe0000;
  // Register byte offsets
  localparam logic [AW-1:0] OFF_CAUSE = 8'h00;
  localparam logic [AW-1:0] OFF_CSET = 8'h04;
  localparam logic [AW-1:0] OFF_MSET = 8'h08;
  localparam logic [AW-1:0] OFF_MCLR = 8'h0c;
  localparam logic [AW-1:0] OFF_ACLR = 8'h10;
  localparam logic [AW-1:0] OFF_AMSK = 8'h14;
  localparam logic [AW-1:0] OFF_CFG = 8'h18;
  localparam logic [AW-1:0] OFF_ALLOC = 8'h20;
  localparam logic [AW-1:0] OFF_THR = 8'h40;
  localparam logic [1:0] THR_PAGE = 2'h1;
  // Configuration bits
  localparam int C_MSGX = 0;  // Message-table mode
  localparam int C_OCD = 1;  // Other-cause-only clear
  localparam int C_IMM = 2;  // Immediate interrupt enable
  localparam int C_AMV = 3;  // Auto mask in vector mode
  // Timing
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 256;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRE_W = 5;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);
  // Bus responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef struct packed {
    logic       valid;
    logic [3:0] vec;
  } msg_t;

  typedef struct packed {
    logic                     aw_h;
    logic [AW-1:0]            aw_a;
    logic                     w_h;
    logic [31:0]              w_d;
    logic [3:0]               w_s;
    logic                     bv;
    logic [1:0]               br;
    logic                     rv;
    logic [31:0]              rd;
    logic [1:0]               rr;
    logic [31:0]              cause;
    logic [31:0]              mask;
    logic [31:0]              aclr;
    logic [31:0]              amsk;
    logic [3:0]               cfg;
    logic [NENT-1:0][3:0]     alloc;
    logic [NV-1:0][IW-1:0]    ivl;
    logic [NV-1:0][IW-1:0]    cnt;
    logic [PRE_W-1:0]         pre;
    msg_t                     msg;
    logic [NV-1:0]            fresh;  // Reloaded, part tick pending
  } state_t;

  // All registers, counters and config reset to zero
  localparam state_t ST_RST = '0;
endpackage
`default_nettype wire

// *** core/irq_moderation.sv ***
// Interrupt cause collection, masking and rate moderation.
// Assumes events and bus come from logic on SYS_CLK_I.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`default_nettype none

module irq_moderation (
  input  wire logic        SYS_CLK_I,   // Core clock
  input  wire logic        RST_I,       // Async reset, high
  input  wire logic        CE_I,        // Clock enable
  input  wire logic        AWVALID_I,   // Write address valid
  output logic             AWREADY_O,   // Write address ready
  input  wire logic [7:0]  AWADDR_I,    // Write byte address
  input  wire logic        WVALID_I,    // Write data valid
  output logic             WREADY_O,    // Write data ready
  input  wire logic [31:0] WDATA_I,     // Write data
  input  wire logic [3:0]  WSTRB_I,     // Byte enables
  output logic             BVALID_O,    // Write response valid
  input  wire logic        BREADY_I,    // Write response ready
  output logic [1:0]       BRESP_O,     // Write response
  input  wire logic        ARVALID_I,   // Read address valid
  output logic             ARREADY_O,   // Read address ready
  input  wire logic [7:0]  ARADDR_I,    // Read byte address
  output logic             RVALID_O,    // Read data valid
  input  wire logic        RREADY_I,    // Read data ready
  output logic [31:0]      RDATA_O,     // Read data
  output logic [1:0]       RRESP_O,     // Read response
  input  wire logic [15:0] Q_EV_I,      // Queue event pulses
  input  wire logic        TIMER_EV_I,  // Transport timer expiry
  input  wire logic [6:0]  LEG_EV_I,    // Pins, mgmt, ecc, link
  output logic             MSG_VALID_O, // Message request pulse
  output logic [3:0]       MSG_VEC_O    // Message vector
);
  im_pkg::state_t            s_q;
  im_pkg::state_t            s_d;
  logic [31:0]               ev;
  logic [31:0]               act;
  logic [31:0]               bm;
  logic [31:0]               wd;
  logic [31:0]               clr;
  logic [31:0]               cset;
  logic [31:0]               mset;
  logic [31:0]               mclr;
  logic [31:0]               rdat;
  logic [im_pkg::NV-1:0]     pend;
  logic [im_pkg::NV-1:0]     rdy_v;
  logic [im_pkg::NV-1:0]     izero;
  logic [im_pkg::NENT-1:0][3:0] svec;
  logic [im_pkg::AW-1:0]     wa;
  logic [3:0]                fidx;
  logic [im_pkg::IW-1:0]     rl_ivl;
  logic                      fire;
  logic                      tick;
  logic                      do_wr;
  logic                      rd_go;
  logic                      wr_ok;
  logic                      rd_ok;
  logic                      msgx;

  // Cause bit served by an allocation source
  function automatic logic [4:0] src_bit(input int k);
    if (k < im_pkg::NQ)
    begin
      src_bit = 5'(k);
    end
    else if (k == im_pkg::E_TIMER)
    begin
      src_bit = 5'(im_pkg::B_TIMER);
    end
    else
    begin
      src_bit = 5'(im_pkg::B_OTHER);
    end
  endfunction

  // Mapped, word-aligned register address
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) &&
             ((a <= im_pkg::OFF_CFG) ||
              (a >= im_pkg::OFF_ALLOC &&
               a < im_pkg::OFF_ALLOC +
                   8'(4 * im_pkg::ALLOC_WORDS)) ||
              (a[7:6] == im_pkg::THR_PAGE));
  endfunction

  // Bus handshakes; ready only while running
  assign AWREADY_O = CE_I && !s_q.aw_h;
  assign WREADY_O = CE_I && !s_q.w_h;
  assign ARREADY_O = CE_I && !s_q.rv;
  assign BVALID_O = s_q.bv;
  assign BRESP_O = s_q.br;
  assign RVALID_O = s_q.rv;
  assign RDATA_O = s_q.rd;
  assign RRESP_O = s_q.rr;
  assign MSG_VALID_O = s_q.msg.valid;
  assign MSG_VEC_O = s_q.msg.vec;

  // Held write, byte lanes and decode
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      bm[8*b +: 8] = {8{s_q.w_s[b]}};
    end
    wd = s_q.w_d & bm;
    wa = s_q.aw_a;
    do_wr = s_q.aw_h && s_q.w_h && !s_q.bv;
    wr_ok = mapped(wa);
    rd_go = ARVALID_I && ARREADY_O;
    rd_ok = mapped(ARADDR_I);
    msgx = s_q.cfg[im_pkg::C_MSGX];
  end

  // Hardware events into cause bits
  always_comb
  begin
    ev = '0;
    for (int q = 0; q < im_pkg::NQ; q++)
    begin
      if (Q_EV_I[q])
      begin
        ev[s_q.alloc[q]] = 1'b1;
      end
    end
    ev[im_pkg::B_TIMER] = TIMER_EV_I;
    ev[im_pkg::B_LEG +: im_pkg::NLEG] = LEG_EV_I;
    ev[im_pkg::B_OTHER] = |LEG_EV_I;
  end

  // Pending vectors and the one that fires
  always_comb
  begin
    act = s_q.cause & s_q.mask;
    pend = '0;
    for (int k = 0; k < im_pkg::NENT; k++)
    begin
      if (!msgx)
      begin
        svec[k] = 4'h0;
      end
      else if (k < im_pkg::NQ)
      begin
        svec[k] = 4'(k);
      end
      else
      begin
        svec[k] = s_q.alloc[k];
      end
      if (act[src_bit(k)])
      begin
        pend[svec[k]] = 1'b1;
      end
    end
    for (int v = 0; v < im_pkg::NV; v++)
    begin
      rdy_v[v] = pend[v] && (s_q.cnt[v] == '0);
    end
    fire = |rdy_v;
    fidx = 4'h0;
    for (int v = im_pkg::NV - 1; v >= 0; v--)
    begin
      if (rdy_v[v])
      begin
        fidx = 4'(v);
      end
    end
    rl_ivl = s_q.ivl[fidx];
    tick = (s_q.pre == im_pkg::PRE_LAST);
  end

  // Read data for the offered read address
  always_comb
  begin
    rdat = '0;
    case (ARADDR_I)
      im_pkg::OFF_CAUSE: rdat = s_q.cause;
      im_pkg::OFF_CSET:  rdat = s_q.cause;
      im_pkg::OFF_MSET:  rdat = s_q.mask;
      im_pkg::OFF_ACLR:  rdat = s_q.aclr;
      im_pkg::OFF_AMSK:  rdat = s_q.amsk;
      im_pkg::OFF_CFG:   rdat = {28'h0, s_q.cfg};
      default:
      begin
        if (ARADDR_I[7:6] == im_pkg::THR_PAGE)
        begin
          rdat = {s_q.cnt[ARADDR_I[5:2]],
                  s_q.ivl[ARADDR_I[5:2]]};
        end
        for (int j = 0; j < im_pkg::NENT; j++)
        begin
          if (ARADDR_I == im_pkg::OFF_ALLOC + 8'(4 * (j / 8)))
          begin
            rdat[4*(j%8) +: 4] = s_q.alloc[j];
          end
        end
      end
    endcase
  end

  // Cause and mask set and clear terms
  always_comb
  begin
    clr = '0;
    cset = '0;
    mset = '0;
    mclr = '0;
    izero = '0;
    if (do_wr)
    begin
      case (wa)
        im_pkg::OFF_CAUSE:
        begin
          clr = wd;
          mclr = wd & s_q.amsk;
        end
        im_pkg::OFF_CSET:
        begin
          cset = wd;
          mset = wd & s_q.amsk;
          for (int k = 0; k < im_pkg::NENT; k++)
          begin
            // Without the enable the counter runs on
            if (s_q.cfg[im_pkg::C_IMM] && wd[src_bit(k)])
            begin
              izero[svec[k]] = 1'b1;
            end
          end
        end
        im_pkg::OFF_MSET: mset = wd;
        im_pkg::OFF_MCLR: mclr = wd;
        default: ;
      endcase
    end
    // Read-to-clear, all or other causes only
    if (rd_go && ARADDR_I == im_pkg::OFF_CAUSE &&
        (!msgx || s_q.cfg[im_pkg::C_OCD]))
    begin
      clr = clr | (s_q.cfg[im_pkg::C_OCD] ?
                   im_pkg::OTHER_BITS : '1);
    end
    // Auto clear and auto mask of the fired vector
    if (fire)
    begin
      for (int k = 0; k < im_pkg::NENT; k++)
      begin
        if (svec[k] == fidx && act[src_bit(k)])
        begin
          clr[src_bit(k)] = clr[src_bit(k)] |
                            s_q.aclr[src_bit(k)];
          if (msgx && s_q.cfg[im_pkg::C_AMV])
          begin
            mclr[src_bit(k)] = mclr[src_bit(k)] |
                               s_q.amsk[src_bit(k)];
          end
        end
      end
    end
  end

  // Next state
  always_comb
  begin
    s_d = s_q;
    // Events and sets win over clears
    s_d.cause = (s_q.cause & ~clr) | ev | cset;
    s_d.mask = (s_q.mask & ~mclr) | mset;
    // Plain registers with byte lanes
    if (do_wr)
    begin
      if (wa == im_pkg::OFF_ACLR)
      begin
        s_d.aclr = (s_q.aclr & ~bm) | wd;
      end
      if (wa == im_pkg::OFF_AMSK)
      begin
        s_d.amsk = (s_q.amsk & ~bm) | wd;
      end
      if (wa == im_pkg::OFF_CFG)
      begin
        s_d.cfg = (s_q.cfg & ~bm[3:0]) | wd[3:0];
      end
      if (wa[7:6] == im_pkg::THR_PAGE && wa[1:0] == 2'h0)
      begin
        s_d.ivl[wa[5:2]] = (s_q.ivl[wa[5:2]] & ~bm[15:0]) |
                           wd[15:0];
      end
      for (int j = 0; j < im_pkg::NENT; j++)
      begin
        if (wa == im_pkg::OFF_ALLOC + 8'(4 * (j / 8)) &&
            bm[4*(j%8)])
        begin
          s_d.alloc[j] = wd[4*(j%8) +: 4];
        end
      end
    end
    // Throttle counters, one per vector
    for (int v = 0; v < im_pkg::NV; v++)
    begin
      if (izero[v])
      begin
        s_d.cnt[v] = '0;
      end
      else if (fire && fidx == 4'(v))
      begin
        s_d.cnt[v] = s_q.ivl[v];
        // Free-running prescaler: a part tick must not count
        s_d.fresh[v] = !tick;
      end
      else if (tick && s_q.fresh[v])
      begin
        s_d.fresh[v] = 1'b0;
      end
      else if (tick && s_q.cnt[v] != '0)
      begin
        s_d.cnt[v] = s_q.cnt[v] - 1'b1;
      end
    end
    // Prescaler, one tick every 26 cycles (260 ns)
    s_d.pre = tick ? '0 : s_q.pre + 1'b1;
    // Message request, one cycle per fire
    s_d.msg.valid = fire;
    if (fire)
    begin
      s_d.msg.vec = fidx;
    end
    // Write channel capture and response
    if (AWVALID_I && AWREADY_O)
    begin
      s_d.aw_h = 1'b1;
      s_d.aw_a = AWADDR_I;
    end
    if (WVALID_I && WREADY_O)
    begin
      s_d.w_h = 1'b1;
      s_d.w_d = WDATA_I;
      s_d.w_s = WSTRB_I;
    end
    if (do_wr)
    begin
      s_d.aw_h = 1'b0;
      s_d.w_h = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = wr_ok ? im_pkg::RESP_OK : im_pkg::RESP_ERR;
    end
    if (s_q.bv && BREADY_I)
    begin
      s_d.bv = 1'b0;
    end
    // Read channel
    if (rd_go)
    begin
      s_d.rv = 1'b1;
      s_d.rd = rd_ok ? rdat : '0;
      s_d.rr = rd_ok ? im_pkg::RESP_OK : im_pkg::RESP_ERR;
    end
    if (s_q.rv && RREADY_I)
    begin
      s_d.rv = 1'b0;
    end
  end

  // State register, frozen while CE_I is low
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s_q <= im_pkg::ST_RST;
    end
    else if (CE_I)
    begin
      s_q <= s_d;
    end
  end

  // Checks
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);

  property p_latch;
    CE_I && ev != '0 |=> (s_q.cause & $past(ev)) == $past(ev);
  endproperty
  a_latch: assert property (p_latch)
    else $error("event not latched into cause");

  property p_masked;
    s_q.mask == '0 |-> !fire;
  endproperty
  a_masked: assert property (p_masked)
    else $error("fire with all causes masked");

  property p_msg;
    CE_I && fire |=> MSG_VALID_O && MSG_VEC_O == $past(fidx);
  endproperty
  a_msg: assert property (p_msg)
    else $error("message missing after fire");

  property p_mset;
    CE_I && do_wr && wa == im_pkg::OFF_MSET
      |=> (s_q.mask & $past(wd)) == $past(wd);
  endproperty
  a_mset: assert property (p_mset)
    else $error("mask set write lost");

  property p_mclr;
    CE_I && do_wr && wa == im_pkg::OFF_MCLR
      |=> (s_q.mask & $past(wd)) == '0;
  endproperty
  a_mclr: assert property (p_mclr)
    else $error("mask clear write lost");

  property p_imm;
    CE_I && do_wr && wa == im_pkg::OFF_CSET && wd[0] &&
      s_q.cfg[im_pkg::C_IMM] && !msgx |=> s_q.cnt[0] == '0;
  endproperty
  a_imm: assert property (p_imm)
    else $error("immediate set left counter running");

  property p_rdclr;
    CE_I && rd_go && ARADDR_I == im_pkg::OFF_CAUSE && !msgx &&
      !s_q.cfg[im_pkg::C_OCD] && ev == '0 && !do_wr
      |=> s_q.cause == '0;
  endproperty
  a_rdclr: assert property (p_rdclr)
    else $error("cause read did not clear");

  property p_single;
    fire && !msgx |-> fidx == 4'h0;
  endproperty
  a_single: assert property (p_single)
    else $error("non-table mode used another counter");

  property p_zero;
    fire |-> s_q.cnt[fidx] == '0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("fire before counter expired");

  property p_reload;
    CE_I && fire && !do_wr
      |=> s_q.cnt[MSG_VEC_O] == $past(rl_ivl);
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter did not reload interval");

  property p_hold0;
    CE_I && s_q.cnt[0] == '0 && !(fire && fidx == 4'h0)
      |=> s_q.cnt[0] == '0;
  endproperty
  a_hold0: assert property (p_hold0)
    else $error("idle counter left zero");

  property p_dec;
    CE_I && tick && s_q.cnt[0] != '0 && !do_wr && !s_q.fresh[0]
      |=> s_q.cnt[0] == $past(s_q.cnt[0]) - 1'b1;
  endproperty
  a_dec: assert property (p_dec)
    else $error("counter missed a tick");

  property p_fire_c;
    CE_I && fire && msgx;
  endproperty
  c_fire: cover property (p_fire_c);

  property p_aclr_c;
    CE_I && fire && (s_q.aclr & act) != '0;
  endproperty
  c_aclr: cover property (p_aclr_c);

  property p_moderated_c;
    CE_I && pend != '0 && !fire ##1 fire;
  endproperty
  c_moderated: cover property (p_moderated_c);
endmodule
`default_nettype wire

// *** test/msg_sink.sv ***
// Host side model: takes message interrupt requests.
// Assumes one-cycle request pulses on the core clock.
`default_nettype none
module msg_sink (
  input  wire logic       clk_i,   // Core clock
  input  wire logic       rst_i,   // Async reset, high
  input  wire logic       valid_i, // Message pulse
  input  wire logic [3:0] vec_i,   // Message vector
  output var  int         count_o, // Messages seen
  output logic [3:0]      vec_o    // Last vector
);
  timeunit 1ns;
  timeprecision 1ps;
  // Posted writes, so every pulse is taken with no back pressure
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_o <= 0;
      vec_o   <= 4'h0;
    end
    else if (valid_i === 1'b1)
    begin
      count_o <= count_o + 1;
      vec_o   <= vec_i;
    end
  end
endmodule
`default_nettype wire

// *** test/interrupt_cause_moderation_bench.sv ***
// Self-checking bench for the interrupt cause and moderation block.
// Assumes a 100 MHz clock, bus and events driven after rising edges.
`default_nettype none
module interrupt_cause_moderation_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        awv = 1'b0;
  logic [7:0]  aw = 8'h00;
  logic        wv = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        bready = 1'b0;
  logic        arv = 1'b0;
  logic [7:0]  ar = 8'h00;
  logic        rready = 1'b0;
  logic [15:0] qev = 16'h0000;
  logic        tev = 1'b0;
  logic [6:0]  lev = 7'h00;
  wire logic   awr, wrdy, bv, arr, rv, mv;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdata;
  wire logic [3:0]  mvec, lvec;
  int          nmsg;
  int          n_errors = 0;
  int          checked = 0;
  logic [31:0] lf = 32'h7f28;
  logic [31:0] rdat;
  logic [1:0]  rres;
  logic [1:0]  wres;

  // Core clock
  always #5 clk = ~clk;

  irq_moderation dut_u (
    .SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(aw),
    .WVALID_I(wv), .WREADY_O(wrdy), .WDATA_I(wd), .WSTRB_I(4'hf),
    .BVALID_O(bv), .BREADY_I(bready), .BRESP_O(br),
    .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ar),
    .RVALID_O(rv), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rr),
    .Q_EV_I(qev), .TIMER_EV_I(tev), .LEG_EV_I(lev),
    .MSG_VALID_O(mv), .MSG_VEC_O(mvec)
  );

  msg_sink host_u (
    .clk_i(clk), .rst_i(rst), .valid_i(mv), .vec_i(mvec),
    .count_o(nmsg), .vec_o(lvec)
  );

  // Random source for masks, mappings and legacy events
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Mask left after a set of a and a clear of b
  function automatic logic [31:0] f_mask(input logic [31:0] a, b);
    return a & ~b;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bus write: address and data together, held until each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awv <= 1'b1;
    aw <= a;
    wv <= 1'b1;
    wd <= d;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awr === 1'b1)
        awv <= 1'b0;
      if (wrdy === 1'b1)
        wv <= 1'b0;
    end while (bv !== 1'b1);
    wres = br;
    bready <= 1'b0;
    chk(n, 3);
  endtask

  // Bus read: data and response taken at the handshake edge
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ar <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arr === 1'b1)
        arv <= 1'b0;
    end while (rv !== 1'b1);
    rdat = rdata;
    rres = rr;
    rready <= 1'b0;
    chk(n, 2);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask

  // One-cycle event pulse on the event inputs
  task automatic pulse(input logic [15:0] q, input logic t,
                       input logic [6:0] l);
    @(posedge clk);
    qev <= q;
    tev <= t;
    lev <= l;
    @(posedge clk);
    qev <= 16'h0000;
    tev <= 1'b0;
    lev <= 7'h00;
  endtask

  // Cycles until the host sees a new message, 999 if none
  task automatic wait_msg(input int lim, output int c);
    int n0;
    n0 = nmsg;
    c = 0;
    while (nmsg == n0 && c < lim)
    begin
      @(posedge clk);
      c++;
    end
    if (nmsg == n0)
      c = 999;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #200000;
    n_errors++;
    $display("mismatch t=%0t watchdog expired", $time);
    complete_run();
  end

  // Main sequence
  initial
  begin
    int c;
    int n0;
    logic [31:0] a;
    logic [3:0] r;
    logic [6:0] l;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(im_pkg::OFF_THR + 8'h14, 32'h0);
    rdchk(im_pkg::OFF_MSET, 32'h0);
    rdchk(8'h3c, 32'h0);
    chk(rres, im_pkg::RESP_ERR);
    wr(8'h3c, 32'hffffffff);
    chk(wres, im_pkg::RESP_ERR);
    lf = lfsr(lf);
    a = lf;
    wr(im_pkg::OFF_MSET, a);
    chk(wres, im_pkg::RESP_OK);
    lf = lfsr(lf);
    wr(im_pkg::OFF_MCLR, lf);
    rdchk(im_pkg::OFF_MSET, f_mask(a, lf));
    chk(rres, im_pkg::RESP_OK);
    wr(im_pkg::OFF_MCLR, 32'hffffffff);
    // Queue 0 mapped to a random cause bit, mask off
    r = lf[3:0];
    wr(im_pkg::OFF_ALLOC, {28'h7654321, r});
    wr(im_pkg::OFF_ALLOC + 8'h04, 32'hfedcba98);
    n0 = nmsg;
    pulse(16'h0001, 1'b0, 7'h00);
    rdchk(im_pkg::OFF_CAUSE, 32'h1 << r);
    rdchk(im_pkg::OFF_CAUSE, 32'h0);
    chk(nmsg, n0);
    wr(im_pkg::OFF_ALLOC, 32'h76543210);
    // Other-only clear with legacy, timer and queue events
    lf = lfsr(lf);
    l = lf[6:0] | 7'h01;
    wr(im_pkg::OFF_CFG, 32'h2);
    pulse(16'h0010, 1'b1, l);
    rdchk(im_pkg::OFF_CAUSE, 32'h80010010 | {8'h0, l, 17'h0});
    rdchk(im_pkg::OFF_CAUSE, 32'h00010010);
    wr(im_pkg::OFF_CAUSE, 32'h00000010);
    rdchk(im_pkg::OFF_CAUSE, 32'h00010000);
    wr(im_pkg::OFF_CAUSE, 32'hffffffff);
    rdchk(im_pkg::OFF_CAUSE, 32'h0);
    // Single counter mode, auto-clear on queue causes
    wr(im_pkg::OFF_CFG, 32'h0);
    wr(im_pkg::OFF_ACLR, 32'h0000ffff);
    wr(im_pkg::OFF_MSET, 32'h8);
    pulse(16'h0008, 1'b0, 7'h00);
    wait_msg(10, c);
    chk(c < 10, 1);
    chk(lvec, 4'h0);
    rdchk(im_pkg::OFF_CAUSE, 32'h0);
    // Table mode, vector 1 throttled at two ticks
    wr(im_pkg::OFF_CFG, 32'h1);
    wr(im_pkg::OFF_THR + 8'h04, 32'h2);
    wr(im_pkg::OFF_MSET, 32'h2);
    pulse(16'h0002, 1'b0, 7'h00);
    wait_msg(10, c);
    chk(c < 10, 1);
    chk(lvec, 4'h1);
    pulse(16'h0002, 1'b0, 7'h00);
    wait_msg(200, c);
    chk(c + 2 >= 52, 1);
    chk(c + 2 <= 84, 1);
    chk(lvec, 4'h1);
    // Software set waits for the counter without immediate enable
    wr(im_pkg::OFF_CSET, 32'h2);
    wait_msg(10, c);
    chk(c, 999);
    wait_msg(70, c);
    chk(c < 70, 1);
    // Immediate enable with auto-mask on software set
    wr(im_pkg::OFF_MCLR, 32'h2);
    wr(im_pkg::OFF_AMSK, 32'h2);
    wr(im_pkg::OFF_CFG, 32'h5);
    wr(im_pkg::OFF_CSET, 32'h2);
    wait_msg(8, c);
    chk(c < 8, 1);
    pulse(16'h0002, 1'b0, 7'h00);
    wr(im_pkg::OFF_CAUSE, 32'h2);
    rdchk(im_pkg::OFF_MSET, 32'h8);
    // Vector mode auto-mask drops the mask on firing
    wr(im_pkg::OFF_CFG, 32'h9);
    wr(im_pkg::OFF_MSET, 32'h2);
    pulse(16'h0002, 1'b0, 7'h00);
    wait_msg(80, c);
    chk(c < 80, 1);
    rdchk(im_pkg::OFF_MSET, 32'h8);
    // Non-table immediate set zeroes the running counter
    wr(im_pkg::OFF_CFG, 32'h4);
    wr(im_pkg::OFF_THR, 32'h3);
    wr(im_pkg::OFF_MSET, 32'h1);
    pulse(16'h0001, 1'b0, 7'h00);
    wait_msg(10, c);
    chk(c < 10, 1);
    wr(im_pkg::OFF_CSET, 32'h1);
    wait_msg(8, c);
    chk(c < 8, 1);
    chk(lvec, 4'h0);
    complete_run();
  end
endmodule
`default_nettype wire
